// ### logic/asu_core.v
// Asynchronous serial transmitter and receiver core with FIFOs and event status
// Notes on behaviour
// - Transmit and receive enable bits set out of reset, global enable clear
// - Disable finishes the character in flight
// - Frame: start, data LSB first, parity, stops
// - Divisor is 16-bit integer, 6-bit fraction
// - Oversample tick at sixteen times baud rate
// - Divisor and line control load together
// - Sixteen entries each, receive adds status
// - Keep sending while transmit storage holds data
// - Busy until storage empty and stops sent
// - Start bit checked on eighth oversample
// - Data sampled every sixteenth oversample, parity
// - Framing error on low stop; store errors
// - Read gives twelve bits, write eight
// - Reset FIFOs single entry; enable gives full
// - Empty, full flags and overrun indication
// - Trigger levels one, two, four, six or seven eighths
// - Trigger levels reset to half full
// - All events ORed onto one request
// - Mask gates request, raw always visible
// - Clear write drops raw and masked bits
// - Receive level event set and clear
// - Transmit level event set and clear
// - Loopback routes transmit line to receiver
// - Break loads one zero, waits for high
// - Overrun when storage full, character lost
`timescale 1ns/10ps
`include "asu_regs.vh"

module asu_core #(
  parameter DEPTH        = 16,                   // Entries per FIFO
  parameter TIMEOUT_BITS = `ASU_TIMEOUT_BITS     // Idle bit periods before timeout
) (
  input  wire        i_mclk,             // System clock, 10 MHz
  input  wire        i_rst_b,            // Asynchronous reset, active low
  input  wire        i_ctl_write,        // Loads the control bits below
  input  wire        i_global_enable,    // Global enable
  input  wire        i_transmit_enable,  // Transmit enable
  input  wire        i_receive_enable,   // Receive enable
  input  wire        i_loopback_enable,  // Internal loopback
  input  wire [15:0] i_integer_divisor,  // Integer divisor, held by software
  input  wire [5:0]  i_fraction_divisor, // Fractional divisor, held by software
  input  wire [7:0]  i_line_control,     // Line control byte
  input  wire        i_line_write,       // Line control write, loads 30-bit config
  input  wire        i_level_write,      // Loads trigger level selects
  input  wire [2:0]  i_tx_level_select,  // Transmit trigger level
  input  wire [2:0]  i_rx_level_select,  // Receive trigger level
  input  wire        i_tx_write,         // Data port write strobe
  input  wire [7:0]  i_tx_data,          // Data port write byte
  input  wire        i_rx_read,          // Data port read strobe
  input  wire        i_error_clear,      // Clears the receive status overrun
  input  wire [6:0]  i_event_mask,       // Event mask bits
  input  wire [6:0]  i_event_clear,      // Write-one-to-clear event bits
  input  wire        i_serial_rx,        // Serial receive line
  output reg         o_serial_tx,        // Serial transmit line
  output reg  [11:0] o_rx_data,          // Head of receive storage
  output reg         o_busy,             // Transmitter busy
  output reg         o_tx_empty,         // Transmit storage empty
  output reg         o_tx_full,          // Transmit storage full
  output reg         o_rx_empty,         // Receive storage empty
  output reg         o_rx_full,          // Receive storage full
  output reg         o_overrun,          // Receive status overrun
  output reg  [6:0]  o_raw_status,       // Raw event status
  output reg  [6:0]  o_masked_status,    // Masked event status
  output reg         o_irq               // Combined interrupt request
);

  // State codes
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_PAR = 3'h3;
  localparam [2:0] ST_STOP = 3'h4;
  localparam [2:0] ST_BRKWAIT = 3'h5;
  localparam [4:0] DEPTH5 = DEPTH[4:0];

  // Control and configuration state
  reg        global_en;      // Global enable
  reg        tx_en;          // Transmit enable
  reg        rx_en;          // Receive enable
  reg        loop_en;        // Loopback
  reg [29:0] cfg;            // Integer, fraction and line control as one word
  reg [2:0]  tx_sel;         // Transmit level select
  reg [2:0]  rx_sel;         // Receive level select

  // Config fields
  wire [21:0] divisor   = cfg[29:8];
  wire        brk_send  = cfg[`ASU_LC_SEND_BREAK];
  wire        par_en    = cfg[`ASU_LC_PARITY_EN];
  wire        par_even  = cfg[`ASU_LC_EVEN_PARITY];
  wire        two_stop  = cfg[`ASU_LC_TWO_STOP];
  wire        fifo_en   = cfg[`ASU_LC_FIFO_EN];
  wire [1:0]  wlen      = cfg[`ASU_LC_WLEN_HI:`ASU_LC_WLEN_LO];
  wire        par_stick = cfg[`ASU_LC_STICK_PARITY];
  wire [2:0]  last_bit  = {1'b1, wlen} + 3'h0;
  wire [4:0]  depth_now = fifo_en ? DEPTH5 : 5'h01;

  // Trigger level in entries from an eighths select
  function [4:0] level_of;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    level_of = 5'h02;  // 1/8
        3'h1:    level_of = 5'h04;  // 1/4
        3'h2:    level_of = 5'h08;  // 1/2
        3'h3:    level_of = 5'h0C;  // 3/4
        default: level_of = 5'h0E;  // 7/8 and above
      endcase
    end
  endfunction

  // Parity bit for a character of the configured length
  function par_bit;
    input [7:0] d;
    input       even;
    input       stick;
    begin
      if (stick)
        par_bit = ~even;
      else
        par_bit = even ? (^d) : ~(^d);
    end
  endfunction

  // Control and config registers
  always @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      global_en <= `ASU_RST_GLOBAL_EN;
      tx_en     <= `ASU_RST_TX_EN;
      rx_en     <= `ASU_RST_RX_EN;
      loop_en   <= `ASU_RST_LOOPBACK;
      cfg       <= 30'h00000000;
      tx_sel    <= `ASU_RST_LEVEL_SEL;
      rx_sel    <= `ASU_RST_LEVEL_SEL;
    end
    else
    begin
      if (i_ctl_write)
      begin
        global_en <= i_global_enable;
        tx_en     <= i_transmit_enable;
        rx_en     <= i_receive_enable;
        loop_en   <= i_loopback_enable;
      end
      // Divisor only takes effect with a line control write
      if (i_line_write)
        cfg <= {i_integer_divisor, i_fraction_divisor, i_line_control};
      if (i_level_write)
      begin
        tx_sel <= i_tx_level_select;
        rx_sel <= i_rx_level_select;
      end
    end
  end

  // Fractional baud generator: accumulate 1/64 steps, tick when divisor reached
  reg  [22:0] frac_acc;
  wire [22:0] next_acc = frac_acc + `ASU_FRAC_ONE;
  wire        tick     = (divisor != 22'h000000) && (next_acc >= {1'b0, divisor});
  always @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      frac_acc <= 23'h000000;
    else if (tick)
      frac_acc <= next_acc - {1'b0, divisor};
    else if (divisor == 22'h000000)
      frac_acc <= 23'h000000;
    else
      frac_acc <= next_acc;
  end

  // Storage arrays, receive entries carry four error bits
  reg [7:0]  tx_mem [0:DEPTH-1];
  reg [11:0] rx_mem [0:DEPTH-1];
  reg [3:0]  tx_wp, tx_rp, rx_wp, rx_rp;
  reg [4:0]  tx_cnt, rx_cnt;
  wire       tx_is_full  = (tx_cnt >= depth_now);
  wire       rx_is_full  = (rx_cnt >= depth_now);
  wire       tx_push     = i_tx_write && !tx_is_full;
  wire       rx_pop      = i_rx_read && (rx_cnt != 5'h00);
  wire       tx_pop;
  wire       rx_store;
  wire [11:0] rx_entry;                        // Completed character with its error bits
  wire       rx_push     = rx_store && !rx_is_full;
  wire [4:0] next_tx_cnt = tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
  wire [4:0] next_rx_cnt = rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};

  // Transmit engine state
  reg [2:0] tx_st;
  reg [3:0] tx_sub;
  reg [2:0] tx_bit;
  reg [7:0] tx_shift;
  reg       tx_line;
  reg       tx_par;
  wire      tx_bit_end = tick && (tx_sub == `ASU_LAST_SUBTICK);
  assign    tx_pop = (tx_st == ST_IDLE) && global_en && tx_en && (tx_cnt != 5'h00);

  // Storage pointers and occupancy; writes beyond depth are dropped
  always @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_wp  <= 4'h0;
      tx_rp  <= 4'h0;
      rx_wp  <= 4'h0;
      rx_rp  <= 4'h0;
      tx_cnt <= 5'h00;
      rx_cnt <= 5'h00;
    end
    else
    begin
      // Leaving FIFO mode leaves stale entries; software drains first
      tx_wp  <= tx_wp + {3'h0, tx_push};
      tx_rp  <= tx_rp + {3'h0, tx_pop};
      rx_wp  <= rx_wp + {3'h0, rx_push};
      rx_rp  <= rx_rp + {3'h0, rx_pop};
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
    end
  end

  // Array writes, no reset needed on data
  always @(posedge i_mclk)
  begin
    if (tx_push)
      tx_mem[tx_wp] <= i_tx_data;
    if (rx_push)
      rx_mem[rx_wp] <= rx_entry;
  end

  // Transmit framing; runs to the end of a character even when disabled
  always @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tx_st    <= ST_IDLE;
      tx_sub   <= 4'h0;
      tx_bit   <= 3'h0;
      tx_shift <= 8'h00;
      tx_line  <= 1'b1;
      tx_par   <= 1'b0;
    end
    else
    begin
      if (tick)
        tx_sub <= tx_sub + 4'h1;
      case (tx_st)
        ST_IDLE:
        begin
          tx_line <= 1'b1;
          if (tx_pop)
          begin
            tx_shift <= tx_mem[tx_rp];
            tx_par   <= par_bit(tx_mem[tx_rp] & (8'hFF >> (3'h3 - {1'b0, wlen})),
                                par_even, par_stick);
            tx_sub   <= 4'h0;
            tx_line  <= 1'b0;
            tx_st    <= ST_START;
          end
        end
        ST_START:
          if (tx_bit_end)
          begin
            tx_line  <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bit   <= 3'h0;
            tx_st    <= ST_DATA;
          end
        ST_DATA:
          if (tx_bit_end)
          begin
            if (tx_bit == last_bit)
            begin
              tx_line <= par_en ? tx_par : 1'b1;
              tx_bit  <= 3'h0;
              tx_st   <= par_en ? ST_PAR : ST_STOP;
            end
            else
            begin
              tx_line  <= tx_shift[0];
              tx_shift <= {1'b0, tx_shift[7:1]};
              tx_bit   <= tx_bit + 3'h1;
            end
          end
        ST_PAR:
          if (tx_bit_end)
          begin
            tx_line <= 1'b1;
            tx_st   <= ST_STOP;
          end
        ST_STOP:
          if (tx_bit_end)
          begin
            // Second stop bit reuses the bit counter
            if (two_stop && (tx_bit == 3'h0))
              tx_bit <= 3'h1;
            else
              tx_st <= ST_IDLE;
          end
        default:
          tx_st <= ST_IDLE;
      endcase
    end
  end

  // Receive engine state; loopback takes the transmit line
  wire      rx_line = loop_en ? o_serial_tx : i_serial_rx;
  reg [2:0] rx_st;
  reg [3:0] rx_sub;
  reg [2:0] rx_bit;
  reg [7:0] rx_shift;
  reg       rx_perr;
  reg       rx_pbit;
  wire      rx_bit_end = tick && (rx_sub == `ASU_LAST_SUBTICK);
  wire [7:0]  rx_char  = rx_shift >> (3'h3 - {1'b0, wlen});
  wire        rx_brk   = !rx_line && (rx_char == 8'h00) && (!par_en || !rx_pbit);
  assign      rx_store = (rx_st == ST_STOP) && rx_bit_end;
  assign      rx_entry = {1'b0, rx_brk, rx_perr && !rx_brk, !rx_line,
                          rx_brk ? 8'h00 : rx_char};

  // Receive framing: start check at mid bit, then one sample per bit
  always @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_st    <= ST_IDLE;
      rx_sub   <= 4'h0;
      rx_bit   <= 3'h0;
      rx_shift <= 8'h00;
      rx_perr  <= 1'b0;
      rx_pbit  <= 1'b0;
    end
    else
    begin
      if (tick)
        rx_sub <= rx_sub + 4'h1;
      case (rx_st)
        ST_IDLE:
          if (global_en && rx_en && !rx_line)
          begin
            rx_sub  <= 4'h0;
            rx_perr <= 1'b0;
            rx_pbit <= 1'b0;
            rx_st   <= ST_START;
          end
        ST_START:
          if (tick && (rx_sub == `ASU_START_SAMPLE))
          begin
            // Glitch shorter than half a bit is ignored
            rx_st  <= rx_line ? ST_IDLE : ST_DATA;
            rx_sub <= 4'h0;
            rx_bit <= 3'h0;
          end
        ST_DATA:
          if (rx_bit_end)
          begin
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == last_bit)
              rx_st <= par_en ? ST_PAR : ST_STOP;
          end
        ST_PAR:
          if (rx_bit_end)
          begin
            rx_pbit <= rx_line;
            rx_perr <= rx_line != par_bit(rx_char, par_even, par_stick);
            rx_st   <= ST_STOP;
          end
        ST_STOP:
          if (rx_bit_end)
            rx_st <= rx_brk ? ST_BRKWAIT : ST_IDLE;
        ST_BRKWAIT:
          if (rx_line)
            rx_st <= ST_IDLE;
        default:
          rx_st <= ST_IDLE;
      endcase
    end
  end

  // Receive timeout: bit periods idle with data waiting
  reg  [3:0] to_sub;
  reg  [7:0] to_bits;
  wire       rx_bit_end_idle = tick && (to_sub == `ASU_LAST_SUBTICK) && (rx_cnt != 5'h00);
  wire       to_hit = rx_bit_end_idle && (to_bits == TIMEOUT_BITS - 1);
  always @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      to_sub  <= 4'h0;
      to_bits <= 8'h00;
    end
    else if ((rx_st != ST_IDLE) || rx_pop || (rx_cnt == 5'h00))
    begin
      to_sub  <= 4'h0;
      to_bits <= 8'h00;
    end
    else
    begin
      if (tick)
        to_sub <= to_sub + 4'h1;
      if (rx_bit_end_idle && !to_hit)
        to_bits <= to_bits + 8'h01;
    end
  end

  // Level crossings; a one-entry mode uses level 1 for receive, 0 for transmit
  wire [4:0] rx_lvl   = fifo_en ? level_of(rx_sel) : 5'h01;
  wire [4:0] tx_lvl   = fifo_en ? level_of(tx_sel) : 5'h00;
  wire       rx_lv_up = (rx_cnt < rx_lvl) && (next_rx_cnt >= rx_lvl);
  wire       rx_lv_dn = next_rx_cnt < rx_lvl;
  wire       tx_lv_dn = (tx_cnt > tx_lvl) && (next_tx_cnt <= tx_lvl);
  wire       tx_lv_up = next_tx_cnt > tx_lvl;
  wire       rx_ovr   = rx_store && rx_is_full;

  // Hardware set events, set wins over a clear in the same cycle
  reg  [6:0] ev_set;
  reg  [6:0] ev_drop;
  always @*
  begin
    ev_set = 7'h00;
    ev_drop = i_event_clear;
    ev_set[`ASU_EV_RX_LEVEL] = rx_lv_up;
    ev_set[`ASU_EV_TX_LEVEL] = tx_lv_dn;
    ev_set[`ASU_EV_TIMEOUT]  = to_hit;
    ev_set[`ASU_EV_FRAME]    = rx_push && rx_entry[`ASU_ERR_FRAME];
    ev_set[`ASU_EV_PARITY]   = rx_push && rx_entry[`ASU_ERR_PARITY];
    ev_set[`ASU_EV_BREAK]    = rx_push && rx_entry[`ASU_ERR_BREAK];
    ev_set[`ASU_EV_OVERRUN]  = rx_ovr;
    ev_drop[`ASU_EV_RX_LEVEL] = i_event_clear[`ASU_EV_RX_LEVEL] || rx_lv_dn;
    ev_drop[`ASU_EV_TX_LEVEL] = i_event_clear[`ASU_EV_TX_LEVEL] || tx_lv_up;
    ev_drop[`ASU_EV_TIMEOUT]  = i_event_clear[`ASU_EV_TIMEOUT] || rx_pop;
  end

  // Raw status vector
  reg  [6:0] raw;
  wire [6:0] next_raw = (raw & ~ev_drop) | ev_set;
  always @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      raw <= `ASU_RST_RAW_STATUS;
    else
      raw <= next_raw;
  end

  // Overrun is sticky in receive status until its own clear
  reg ovr;
  always @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      ovr <= 1'b0;
    else if (rx_ovr)
      ovr <= 1'b1;
    else if (i_error_clear)
      ovr <= 1'b0;
  end

  // Registered outputs, built from next-state values so they line up with the registers; serial line one cycle after tx_line
  always @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_serial_tx     <= 1'b1;
      o_rx_data       <= 12'h000;
      o_busy          <= 1'b0;
      o_tx_empty      <= 1'b1;
      o_tx_full       <= 1'b0;
      o_rx_empty      <= 1'b1;
      o_rx_full       <= 1'b0;
      o_overrun       <= 1'b0;
      o_raw_status    <= `ASU_RST_RAW_STATUS;
      o_masked_status <= 7'h00;
      o_irq           <= 1'b0;
    end
    else
    begin
      // Break send holds the line low regardless of the engine
      o_serial_tx     <= tx_line && !brk_send;
      o_rx_data       <= rx_mem[rx_rp + {3'h0, rx_pop}];
      o_busy          <= (next_tx_cnt != 5'h00) || (tx_st != ST_IDLE) || tx_pop;
      o_tx_empty      <= next_tx_cnt == 5'h00;
      o_tx_full       <= next_tx_cnt >= depth_now;
      o_rx_empty      <= next_rx_cnt == 5'h00;
      o_rx_full       <= next_rx_cnt >= depth_now;
      o_overrun       <= rx_ovr || (ovr && !i_error_clear);
      o_raw_status    <= next_raw;
      o_masked_status <= next_raw & i_event_mask;
      o_irq           <= |(next_raw & i_event_mask);
    end
  end

endmodule

// ### shared/asu_regs.vh
// Constants for the asynchronous serial core: field positions, reset values, timing counts
`ifndef ASU_REGS_VH
`define ASU_REGS_VH

// Line control byte, field positions
`define ASU_LC_SEND_BREAK   0
`define ASU_LC_PARITY_EN    1
`define ASU_LC_EVEN_PARITY  2
`define ASU_LC_TWO_STOP     3
`define ASU_LC_FIFO_EN      4
`define ASU_LC_WLEN_LO      5
`define ASU_LC_WLEN_HI      6
`define ASU_LC_STICK_PARITY 7

// Control register reset values
`define ASU_RST_GLOBAL_EN   1'b0
`define ASU_RST_TX_EN       1'b1
`define ASU_RST_RX_EN       1'b1
`define ASU_RST_LOOPBACK    1'b0

// Trigger level selects, reset is the half-full point
`define ASU_RST_LEVEL_SEL   3'h2

// Event bit positions in raw and masked status
`define ASU_EV_RX_LEVEL     0
`define ASU_EV_TX_LEVEL     1
`define ASU_EV_TIMEOUT      2
`define ASU_EV_FRAME        3
`define ASU_EV_PARITY       4
`define ASU_EV_BREAK        5
`define ASU_EV_OVERRUN      6
`define ASU_RST_RAW_STATUS  7'h02

// Receive entry error bits above the data byte
`define ASU_ERR_FRAME       8
`define ASU_ERR_PARITY      9
`define ASU_ERR_BREAK       10
`define ASU_ERR_OVERRUN     11

// Timing counts
`define ASU_OVERSAMPLE      16
`define ASU_START_SAMPLE    4'h7
`define ASU_LAST_SUBTICK    4'hF
`define ASU_FRAC_ONE        23'h000040
`define ASU_TIMEOUT_BITS    32

`endif

// ### tb/asu_core_chk.sv
// Port-level checker for the asynchronous serial core
`timescale 1ns/10ps
module asu_core_chk (
  input wire       i_mclk,          // System clock
  input wire       i_rst_b,         // Reset, active low
  input wire       i_tx_write,      // Push strobe
  input wire       i_rx_read,       // Pop strobe
  input wire [6:0] i_event_mask,    // Event mask
  input wire [6:0] i_event_clear,   // Event clear
  input wire       o_serial_tx,     // Serial output
  input wire       o_busy,          // Transmitter busy
  input wire       o_tx_empty,      // Tx storage empty
  input wire       o_tx_full,       // Tx storage full
  input wire       o_rx_empty,      // Rx storage empty
  input wire       o_rx_full,       // Rx storage full
  input wire [6:0] o_raw_status,    // Raw events
  input wire [6:0] o_masked_status, // Masked events
  input wire       o_irq            // Combined request
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // Line idle and tx level pending right after release
  chk_reset_status: assert property ($rose(i_rst_b) |-> o_serial_tx && o_raw_status == 7'h02)
    else $error("status after reset wrong");
  // A push that is taken raises busy
  chk_busy_push: assert property (i_tx_write && !o_tx_full |=> o_busy)
    else $error("busy not raised by push");
  // A push into empty storage clears the empty flag
  chk_push_fill: assert property (i_tx_write && o_tx_empty |=> !o_tx_empty)
    else $error("tx empty stuck after push");
  // Busy may drop only with storage drained
  chk_busy_fall: assert property ($fell(o_busy) |-> o_tx_empty)
    else $error("busy fell with data queued");
  // Nothing but idle level while not busy; no break is sent here
  chk_idle_line: assert property (!o_busy |-> o_serial_tx)
    else $error("line low while idle");
  // Empty and full never together
  chk_flag_excl: assert property (!(o_tx_full && o_tx_empty) && !(o_rx_full && o_rx_empty))
    else $error("empty and full together");
  // Masked view never shows an event that is not raw
  chk_mask_subset: assert property ((o_masked_status & ~o_raw_status) == 7'h00)
    else $error("masked bit without raw bit");
  // One request for all masked events
  chk_irq_or: assert property (o_irq == (|o_masked_status))
    else $error("request differs from masked events");
  // With no mask for two cycles nothing is masked through
  chk_mask_zero: assert property (
    i_event_mask == 7'h00 && $past(i_event_mask) == 7'h00 |-> o_masked_status == 7'h00)
    else $error("event passed a cleared mask");
  // Clear drops overrun when no new overrun can land
  chk_clear_overrun: assert property (i_event_clear[6] && !o_rx_full |=> !o_raw_status[6])
    else $error("overrun not cleared");
  // A pop from full storage frees a place
  chk_pop_full: assert property (i_rx_read && o_rx_full |=> !o_rx_full)
    else $error("rx full after pop");
  cov_irq: cover property ($rose(o_irq));
  cov_overrun: cover property ($rose(o_raw_status[6]));
  cov_tx_done: cover property ($fell(o_busy));
endmodule
bind asu_core asu_core_chk asu_core_chk_i (.*);

// ### tb/asu_far_end.sv
// Far-side serial model: frames bytes to the device and decodes its frames
`timescale 1ns/10ps
module asu_far_end #(
  parameter BITC = 16     // Clocks per bit at the divisor in use
) (
  input  wire i_mclk,     // Shared clock
  input  wire i_line_in,  // Device transmit line
  output reg  o_line_out  // Device receive line, idle high
);
  reg [7:0] got [$];      // Bytes decoded from the device
  reg [7:0] sh;           // Decode shift register
  initial o_line_out = 1'b1;
  // Hold a level for n clocks, moving just after an edge
  task hold(input v, input int n);
    o_line_out = v;
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // Start, data LSB first, one stop level, then an idle bit
  task send(input [7:0] d, input stop);
    hold(1'b0, BITC);
    for (int i = 0; i < 8; i++)
      hold(d[i], BITC);
    hold(stop, BITC);
    hold(1'b1, BITC);
  endtask
  // Decode at mid bit; a frame with a low stop is dropped, not guessed
  always @(negedge i_line_in)
  begin
    repeat (BITC / 2) @(posedge i_mclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BITC) @(posedge i_mclk);
      sh[i] = i_line_in;
    end
    repeat (BITC) @(posedge i_mclk);
    if (i_line_in === 1'b1)
      got.push_back(sh);
  end
endmodule

// ### tb/test_asu_core.sv
// Self-checking bench for the asynchronous serial core
`timescale 1ns/10ps
module test_asu_core;
  reg         i_mclk = 1'b0;            // System clock
  reg         i_rst_b = 1'b0;           // Reset, active low
  reg         i_ctl_write = 1'b0;       // Control load
  reg         i_global_enable = 1'b0;   // Global enable
  reg         i_loopback_enable = 1'b0; // Loopback
  reg  [7:0]  i_line_control = 8'h00;   // Line control byte
  reg         i_line_write = 1'b0;      // Config load
  reg         i_level_write = 1'b0;     // Level load
  reg  [2:0]  i_rx_level_select = 3'h2; // Rx trigger level
  reg         i_tx_write = 1'b0;        // Push strobe
  reg  [7:0]  i_tx_data = 8'h00;        // Push byte
  reg         i_rx_read = 1'b0;         // Pop strobe
  reg         i_error_clear = 1'b0;     // Overrun clear
  reg  [6:0]  i_event_mask = 7'h00;     // Event mask
  reg  [6:0]  i_event_clear = 7'h00;    // Event clear
  wire        i_serial_rx;              // Far side to device
  wire        o_serial_tx, o_busy, o_tx_empty, o_tx_full;
  wire        o_rx_empty, o_rx_full, o_overrun, o_irq;
  wire [11:0] o_rx_data;                // Head entry
  wire [6:0]  o_raw_status, o_masked_status;
  int         err_count = 0;            // Mismatches
  int         tests_run = 0;            // Comparisons
  int         cyc = 0;                  // Hang guard
  always #50 i_mclk = ~i_mclk;
  // Divisor one: a tick every clock, so a bit is 16 clocks
  asu_core asu_core_i (.i_mclk, .i_rst_b, .i_ctl_write, .i_global_enable,
    .i_transmit_enable(1'b1), .i_receive_enable(1'b1), .i_loopback_enable,
    .i_integer_divisor(16'h0001), .i_fraction_divisor(6'h00), .i_line_control,
    .i_line_write, .i_level_write, .i_tx_level_select(3'h2), .i_rx_level_select,
    .i_tx_write, .i_tx_data, .i_rx_read, .i_error_clear, .i_event_mask,
    .i_event_clear, .i_serial_rx, .o_serial_tx, .o_rx_data, .o_busy, .o_tx_empty,
    .o_tx_full, .o_rx_empty, .o_rx_full, .o_overrun, .o_raw_status,
    .o_masked_status, .o_irq);
  asu_far_end asu_far_end_i (.i_mclk, .i_line_in(o_serial_tx), .o_line_out(i_serial_rx));
  task test_done();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Whole run is a few thousand clocks; this ceiling only catches hangs
  always @(posedge i_mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      test_done();
    end
  end
  task check(input [11:0] seen, input [11:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs always move 1 ns after the edge
  task step();
    @(posedge i_mclk);
    #1;
  endtask
  // Disable, then load divisor and line control in the same cycle as enable
  task cfg(input [7:0] lc, input lb);
    i_global_enable = 1'b0;
    i_ctl_write = 1'b1;
    step();
    i_line_control = lc;
    i_line_write = 1'b1;
    i_global_enable = 1'b1;
    i_loopback_enable = lb;
    step();
    i_line_write = 1'b0;
    i_ctl_write = 1'b0;
  endtask
  // Push one or two bytes with the strobe held high
  task put(input [7:0] a, input [7:0] b, input int n);
    i_tx_write = 1'b1;
    i_tx_data = a;
    step();
    if (n > 1)
    begin
      i_tx_data = b;
      step();
    end
    i_tx_write = 1'b0;
  endtask
  // Wait for an entry, compare the head, then pop it
  task get(input [11:0] exp);
    int n;
    n = 0;
    while (o_rx_empty !== 1'b0 && n < 400)
    begin
      step();
      n++;
    end
    if (n == 400)
      err_count = err_count + 1;
    step();
    check(o_rx_data, exp);
    i_rx_read = 1'b1;
    step();
    i_rx_read = 1'b0;
  endtask
  task idle_tx();
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < 800)
    begin
      step();
      n++;
    end
    if (n == 800)
      err_count = err_count + 1;
  endtask
  initial
  begin
    repeat (12) step();
    check(o_serial_tx, 1'b1);
    check(o_raw_status, 7'h02);
    check(o_tx_empty, 1'b1);
    check(o_rx_empty, 1'b1);
    i_rst_b = 1'b1;
    $display("test reset done");
    cfg(8'h70, 1'b0);
    put(8'hA5, 8'h3C, 2);
    check(o_busy, 1'b1);
    idle_tx();
    check(asu_far_end_i.got.size(), 2);
    check(asu_far_end_i.got[0], 8'hA5);
    check(asu_far_end_i.got[1], 8'h3C);
    check(o_tx_empty, 1'b1);
    $display("test transmit done");
    cfg(8'h70, 1'b1);
    put(8'h5A, 8'h00, 1);
    get(12'h05A);
    idle_tx();
    $display("test loopback done");
    cfg(8'h70, 1'b0);
    asu_far_end_i.hold(1'b0, 3);
    asu_far_end_i.hold(1'b1, 40);
    check(o_rx_empty, 1'b1);
    asu_far_end_i.send(8'h81, 1'b0);
    get(12'h181);
    asu_far_end_i.hold(1'b0, 200);
    asu_far_end_i.hold(1'b1, 40);
    get(12'h500);
    check(o_rx_empty, 1'b1);
    $display("test errors done");
    i_rx_level_select = 3'h0;
    i_level_write = 1'b1;
    i_event_clear = 7'h7F;
    step();
    i_level_write = 1'b0;
    i_event_clear = 7'h00;
    i_event_mask = 7'h01;
    asu_far_end_i.send(8'h11, 1'b1);
    asu_far_end_i.send(8'h22, 1'b1);
    check(o_raw_status[0], 1'b1);
    check(o_masked_status, 7'h01);
    check(o_irq, 1'b1);
    i_event_mask = 7'h00;
    step();
    check(o_irq, 1'b0);
    check(o_raw_status[0], 1'b1);
    i_event_clear = 7'h01;
    step();
    i_event_clear = 7'h00;
    check(o_raw_status[0], 1'b0);
    get(12'h011);
    get(12'h022);
    $display("test levels done");
    cfg(8'h60, 1'b0);
    asu_far_end_i.send(8'h44, 1'b1);
    asu_far_end_i.send(8'h55, 1'b1);
    check(o_rx_full, 1'b1);
    check(o_overrun, 1'b1);
    check(o_raw_status[6], 1'b1);
    repeat (560) step();
    check(o_raw_status[2], 1'b1);
    get(12'h044);
    check(o_rx_empty, 1'b1);
    i_error_clear = 1'b1;
    step();
    i_error_clear = 1'b0;
    check(o_overrun, 1'b0);
    put(8'h66, 8'h00, 1);
    idle_tx();
    check(o_raw_status[1], 1'b1);
    $display("test overrun done");
    test_done();
  end
endmodule
